// *** bench/sgp_gpio_asserts.sv ***
// Port-level checks on the general purpose port top
`timescale 1ns/1ps
`default_nettype none
module sgp_gpio_asserts
	import sgp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [PIN_TOTAL-1:0] pad_out,
	input wire logic [PIN_TOTAL-1:0] pad_oe,
	input wire logic twi_active,
	input wire logic tap_mode_select,
	input wire logic test_access_enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire logic acc = psel && penable;
	ready_in_access_a: assert property (pready == acc) else $error("pready off access phase");
	bad_align_a: assert property (acc && !pwrite && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
		else $error("unaligned read not refused");
	reset_state_a: assert property ($rose(reset_n) |-> pad_oe[PIN_TOTAL-1:6] == '0 && pad_oe[4:0] == '0 && test_access_enable)
		else $error("state after reset wrong");
	latch_drive_a: assert property (acc && pwrite && !pslverr && (paddr == 12'h064 || paddr == 12'h068)
		|=> (pad_oe[111:96] & (pad_out[111:96] ^ $past(pwdata[15:0]))) == 16'h0) else $error("lamp drive wrong");
	tap_owns_a: assert property (test_access_enable |-> !pad_oe[TEST_MODE_BIT] && !pad_oe[TEST_CLOCK_BIT]
		&& !pad_oe[TEST_DATA_IN_BIT]) else $error("port drives test pin");
	tap_release_a: assert property (!test_access_enable |-> !tap_mode_select) else $error("mode select kept");
	tap_off_a: assert property ($fell(test_access_enable)
		|-> $past(acc && pwrite && paddr == DEBUG_CONFIG_ADDR && !pwdata[TEST_ENABLE_BIT])) else $error("test off unasked");
	twi_owns_a: assert property (twi_active && $past(twi_active) |-> !pad_oe[TWI_CLOCK_BIT] && !pad_oe[TWI_DATA_BIT])
		else $error("port drives two-wire pin");
	cover property (acc && pslverr);
	cover property ($fell(test_access_enable));
	cover property (twi_active && acc);
endmodule
bind sgp_gpio_top sgp_gpio_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pad_out(pad_out), .pad_oe(pad_oe), .twi_active(twi_active), .tap_mode_select(tap_mode_select),
	.test_access_enable(test_access_enable));
`default_nettype wire

// *** bench/sgp_pin_world.sv ***
// Pins, pulls and buttons outside the port
`timescale 1ns/1ps
`default_nettype none
module sgp_pin_world
	import sgp_pkg::*;
(
	input wire logic [PIN_TOTAL-1:0] pad_out,
	input wire logic [PIN_TOTAL-1:0] pad_oe,
	input wire logic [PIN_TOTAL-1:0] ext_val,
	input wire logic [PIN_TOTAL-1:0] ext_en,
	output logic [PIN_TOTAL-1:0] pad_in
);
	// Released buttons pull low, every other pin pulls high
	localparam logic [PIN_TOTAL-1:0] PULL_LOW = (PIN_TOTAL'(1) << (PORT_G * 16 + BUTTON_ONE_BIT))
		| (PIN_TOTAL'(1) << (PORT_G * 16 + BUTTON_TWO_BIT)) | (PIN_TOTAL'(1) << BUTTON_THREE_BIT);
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & ~PULL_LOW);
endmodule
`default_nettype wire

// *** bench/tb_sgp_gpio_top.sv ***
// Self-checking bench for the general purpose port top
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module tb_sgp_gpio_top;
	import sgp_pkg::*;
	logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, twi_active = 0, tap_data_out = 0, tde = 0;
	logic [ADDR_WIDTH-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, seed = 32'h6eb7;
	logic pready, pslverr, err, tes, ten = 1, tck, tms, tdi;
	logic [PIN_TOTAL-1:0] pad_in, pad_out, pad_oe, ext_val = '0, ext_en = '0;
	logic [15:0] dir_s [7], latch_s [7], drain_s [7];
	int fails = 0, num_checks = 0;
	initial forever #2.5 ref_clk = ~ref_clk;
	sgp_gpio_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .twi_active(twi_active), .tap_data_out(tap_data_out),
		.tap_data_out_en(tde), .tap_clock(tck), .tap_mode_select(tms), .tap_data_in(tdi), .test_access_enable(tes));
	sgp_pin_world world (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] blk(input int p);
		return (p == PORT_A) ? ({12'h0, twi_active, twi_active, 2'h0} | {10'h0, ten, ten, 2'h0, ten, ten}) : 16'h0;
	endfunction
	// Test controller's own drive on its data-out pin
	function automatic logic [15:0] tapo(input int p);
		return (p == PORT_A && ten) ? 16'h1 << TEST_DATA_OUT_BIT : 16'h0;
	endfunction
	function automatic logic [15:0] eoe(input int p);
		return (~dir_s[p] & ~blk(p) & ~(drain_s[p] & latch_s[p])) | (tapo(p) & {16{tde}});
	endfunction
	function automatic logic [15:0] eout(input int p);
		return ((latch_s[p] & ~drain_s[p] & ~tapo(p)) | (tapo(p) & {16{tap_data_out}})) & eoe(p);
	endfunction
	function automatic logic [15:0] elvl(input int p);
		logic [15:0] pd, e, x;
		pd = (p == PORT_G) ? 16'h00c0 : ((p == PORT_A) ? 16'h0001 : 16'h0);
		e = ext_en[p*16 +: 16];
		x = (e & ext_val[p*16 +: 16]) | (~e & ~pd);
		return ((eoe(p) & latch_s[p]) | (~eoe(p) & x)) & ~blk(p);
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) fails++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setreg(input int p, input int r, input logic [15:0] v);
		apb(1'b1, 12'(p * 16 + r * 4), {16'h0, v});
		if (r == 0) dir_s[p] = v;
		else if (r == 3) drain_s[p] = v;
		else latch_s[p] = v;
	endtask
	task automatic chk_port(input int p);
		logic [2:0] tpin;
		repeat (4) @(posedge ref_clk);
		tpin = {pad_in[TEST_CLOCK_BIT], pad_in[TEST_MODE_BIT], pad_in[TEST_DATA_IN_BIT]};
		`CHK(pad_oe[p*16 +: 16], eoe(p))
		`CHK(pad_out[p*16 +: 16] & eoe(p), eout(p))
		`CHK({tck, tms, tdi}, tpin & {3{ten}})
		apb(1'b0, 12'(p * 16 + 4), 32'h0);
		`CHK(rd, {16'h0, latch_s[p]})
		apb(1'b0, 12'(p * 16 + 8), 32'h0);
		`CHK(rd, {16'h0, elvl(p)})
		`CHK(tes, ten)
	endtask
	initial begin
		#100000;
		fails++;
		final_report;
	end
	initial begin
		for (int p = 0; p < PORT_COUNT; p++) begin
			dir_s[p] = DIRECTION_RESET;
			latch_s[p] = LATCH_RESET;
			drain_s[p] = DRAIN_RESET;
		end
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < PORT_COUNT * 4; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0);
			`CHK(rd, {16'h0, i % 4 == 0 ? DIRECTION_RESET : (i % 4 == 2 ? elvl(i / 4) : 16'h0)})
		end
		apb(1'b0, DEBUG_CONFIG_ADDR, 32'h0);
		`CHK(rd, 32'h1 << TEST_ENABLE_BIT)
		foreach (dir_s[k]) begin
			apb(k[0], 12'h071 + 12'(k * 12'h45), 32'h0);
			`CHK({err, k[0] ? 32'h0 : rd}, {1'b1, 32'h0})
		end
		setreg(PORT_G, 0, 16'h0fff);
		setreg(PORT_G, 1, 16'ha000);
		chk_port(PORT_G);
		for (int i = 0; i < 48; i++) begin
			int p;
			seed = nx(seed);
			p = int'(seed[7:0]) % PORT_COUNT;
			if (i == 24) begin
				apb(1'b1, DEBUG_CONFIG_ADDR, 32'h0);
				ten = 1'b0;
			end
			twi_active <= seed[8];
			tap_data_out <= seed[9];
			tde <= seed[10];
			ext_val <= {seed[15:0], ~seed, nx(seed), seed};
			ext_en <= {~seed[15:0], seed, ~seed, nx(seed)};
			setreg(p, 0, seed[15:0]);
			setreg(p, 3, seed[31:16]);
			seed = nx(seed);
			setreg(p, seed[20] ? 1 : 2, seed[15:0]);
			chk_port(p);
		end
		final_report;
	end
endmodule
`default_nettype wire

// *** logic/sgp_gpio_top.sv ***
// Seven 16-bit general purpose ports with APB register access
// Notes on behaviour
// - Up to seven ports A to G, 16 bits each; absent bits read zero, except direction bits, which read one.
// - Direction bit 0 makes the pin an output, 1 an input.
// - Latch writes update the latch; output pins drive their latch bit.
// - Latch reads return the last written value, not the pin level.
// - Pin-level reads return the present state of every unblocked pin; blocked pins read zero.
// - Writing the pin-level register equals writing the latch.
// - Drain-type bit 0 is push-pull, 1 is open-drain.
// - Driver type applies to any output pin, independently per pin.
// - Test controller enabled after reset; owns its four shared pins meanwhile.
// - Clearing the test enable bit returns the shared pins to the ports.
// - Two-wire pins are not general purpose while that controller is active.
// - Lamps on port G bits 12 to 15; latch 1 lights a lamp.
// - Third button's level is withheld until the test controller is disabled.
`timescale 1ns/1ps
`default_nettype none
module sgp_gpio_top
	import sgp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PIN_TOTAL-1:0] pad_in,
	output logic [PIN_TOTAL-1:0] pad_out,
	output logic [PIN_TOTAL-1:0] pad_oe,
	input wire logic twi_active,
	input wire logic tap_data_out,
	input wire logic tap_data_out_en,
	output logic tap_clock,
	output logic tap_mode_select,
	output logic tap_data_in,
	output logic test_access_enable
);
	sgp_port_if port_bus [PORT_COUNT] ();

	logic [PIN_TOTAL-1:0] drive_out;
	logic [PIN_TOTAL-1:0] drive_oe;
	logic [PIN_TOTAL-1:0] blocked;
	logic [PIN_TOTAL-1:0] level_view;
	logic [PORT_COUNT*PORT_WIDTH-1:0] dir_all;
	logic [PORT_COUNT*PORT_WIDTH-1:0] latch_all;
	logic [PORT_COUNT*PORT_WIDTH-1:0] drain_all;
	logic setup_phase;
	logic wr_take;
	logic [2:0] sel_port;
	logic [1:0] sel_reg;
	logic sel_hit;
	logic cfg_hit;

	logic test_enable_reg;
	logic test_enable_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic err_reg;
	logic err_next;
	sgp_access_e acc_reg;
	sgp_access_e acc_next;

	// Port index of an address inside the port window
	function automatic logic [2:0] addr_port(input logic [ADDR_WIDTH-1:0] a);
		addr_port = a[6:4];
	endfunction

	// Register index of an address inside a port
	function automatic logic [1:0] addr_reg(input logic [ADDR_WIDTH-1:0] a);
		addr_reg = a[3:2];
	endfunction

	// Whether an address names a port register of a present port
	function automatic logic addr_is_port(input logic [ADDR_WIDTH-1:0] a);
		addr_is_port = (a < PORT_SPAN) && (a[1:0] == 2'h0)
			&& (PRESENT_MASK[int'(addr_port(a))*PORT_WIDTH +: PORT_WIDTH] != 16'h0000);
	endfunction

	assign setup_phase = psel & ~penable;
	assign sel_port = addr_port(paddr);
	assign sel_reg = addr_reg(paddr);
	assign sel_hit = addr_is_port(paddr);
	assign cfg_hit = (paddr == DEBUG_CONFIG_ADDR);
	// Writes act at the completing access edge
	assign wr_take = psel & penable & pwrite & ~err_reg;

	genvar p;
	generate
		for (p = 0; p < PORT_COUNT; p = p + 1) begin : g_port
			logic hit_here;
			assign hit_here = wr_take && addr_is_port(paddr) && (addr_port(paddr) == 3'(p));
			assign port_bus[p].wdata = pwdata[PORT_WIDTH-1:0];
			assign port_bus[p].wr_direction = hit_here && (addr_reg(paddr) == REG_DIRECTION);
			// Pin-level writes land in the latch
			assign port_bus[p].wr_latch = hit_here
				&& ((addr_reg(paddr) == REG_LATCH) || (addr_reg(paddr) == REG_LEVEL));
			assign port_bus[p].wr_drain = hit_here && (addr_reg(paddr) == REG_DRAIN);

			sgp_port_regs #(
				.PRESENT(PRESENT_MASK[p*PORT_WIDTH +: PORT_WIDTH])
			) u_regs (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.port(port_bus[p])
			);

			sgp_pad_drive u_drive (
				.port(port_bus[p]),
				.drive_out(drive_out[p*PORT_WIDTH +: PORT_WIDTH]),
				.drive_oe(drive_oe[p*PORT_WIDTH +: PORT_WIDTH])
			);

			assign dir_all[p*PORT_WIDTH +: PORT_WIDTH] = port_bus[p].direction;
			assign latch_all[p*PORT_WIDTH +: PORT_WIDTH] = port_bus[p].latch;
			assign drain_all[p*PORT_WIDTH +: PORT_WIDTH] = port_bus[p].drain;
		end
	endgenerate

	// Pins taken from general purpose use by another controller
	always_comb begin
		blocked = '0;
		if (test_enable_reg) begin
			blocked[PORT_A*PORT_WIDTH + TEST_MODE_BIT] = 1'b1;
			blocked[PORT_A*PORT_WIDTH + TEST_CLOCK_BIT] = 1'b1;
			blocked[PORT_A*PORT_WIDTH + TEST_DATA_IN_BIT] = 1'b1;
			blocked[PORT_A*PORT_WIDTH + TEST_DATA_OUT_BIT] = 1'b1;
		end
		if (twi_active) begin
			blocked[TWI_PORT*PORT_WIDTH + TWI_CLOCK_BIT] = 1'b1;
			blocked[TWI_PORT*PORT_WIDTH + TWI_DATA_BIT] = 1'b1;
		end
	end

	// Pad drive: ports own unblocked present pins, the test controller its data out
	always_comb begin
		pad_out = drive_out & PRESENT_MASK & ~blocked;
		pad_oe = drive_oe & PRESENT_MASK & ~blocked;
		if (test_enable_reg) begin
			pad_out[PORT_A*PORT_WIDTH + TEST_DATA_OUT_BIT] = tap_data_out;
			pad_oe[PORT_A*PORT_WIDTH + TEST_DATA_OUT_BIT] = tap_data_out_en;
		end
	end

	// Test controller inputs see their pins only while it is enabled
	assign tap_clock = test_enable_reg & pad_in[PORT_A*PORT_WIDTH + TEST_CLOCK_BIT];
	assign tap_mode_select = test_enable_reg & pad_in[PORT_A*PORT_WIDTH + TEST_MODE_BIT];
	assign tap_data_in = test_enable_reg & pad_in[PORT_A*PORT_WIDTH + TEST_DATA_IN_BIT];
	assign test_access_enable = test_enable_reg;

	// Button on the mode-select pin is withheld while blocked
	assign level_view = pad_in & PRESENT_MASK & ~blocked;

	// Access state, read data and error are captured in the setup cycle
	always_comb begin
		acc_next = acc_reg;
		rdata_next = rdata_reg;
		err_next = err_reg;
		test_enable_next = test_enable_reg;
		case (acc_reg)
			SGP_ACC_IDLE: begin
				if (setup_phase) begin
					acc_next = SGP_ACC_WAIT;
					rdata_next = 32'h0000_0000;
					err_next = 1'b0;
					if (sel_hit) begin
						if (sel_reg == REG_DIRECTION) begin
							rdata_next[PORT_WIDTH-1:0] = dir_all[int'(sel_port)*PORT_WIDTH +: PORT_WIDTH];
						end else if (sel_reg == REG_LATCH) begin
							rdata_next[PORT_WIDTH-1:0] = latch_all[int'(sel_port)*PORT_WIDTH +: PORT_WIDTH];
						end else if (sel_reg == REG_LEVEL) begin
							rdata_next[PORT_WIDTH-1:0] = level_view[int'(sel_port)*PORT_WIDTH +: PORT_WIDTH];
						end else begin
							rdata_next[PORT_WIDTH-1:0] = drain_all[int'(sel_port)*PORT_WIDTH +: PORT_WIDTH];
						end
					end else if (cfg_hit) begin
						rdata_next[TEST_ENABLE_BIT] = test_enable_reg;
					end else begin
						err_next = 1'b1;
					end
				end
			end
			SGP_ACC_WAIT: begin
				if (psel && penable) begin
					acc_next = SGP_ACC_IDLE;
					if (pwrite && cfg_hit) begin
						test_enable_next = pwdata[TEST_ENABLE_BIT];
					end
				end else if (!psel) begin
					acc_next = SGP_ACC_IDLE;
				end
			end
			default: begin
				acc_next = SGP_ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_reg <= SGP_ACC_IDLE;
			rdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
			test_enable_reg <= TEST_ENABLE_RESET;
		end else begin
			acc_reg <= acc_next;
			rdata_reg <= rdata_next;
			err_reg <= err_next;
			test_enable_reg <= test_enable_next;
		end
	end

	// Zero wait states: the access phase always completes
	assign pready = psel & penable;
	assign prdata = rdata_reg;
	assign pslverr = psel & penable & err_reg;
endmodule
`default_nettype wire

// *** logic/sgp_pad_drive.sv ***
// Per-pin output driver: push-pull or open-drain
`timescale 1ns/1ps
`default_nettype none
module sgp_pad_drive
	import sgp_pkg::*;
(
	sgp_port_if.pads port,
	output logic [PORT_WIDTH-1:0] drive_out,
	output logic [PORT_WIDTH-1:0] drive_oe
);
	genvar b;
	generate
		for (b = 0; b < PORT_WIDTH; b = b + 1) begin : g_pin
			// Open drain pulls low for 0 and releases for 1
			assign drive_out[b] = port.latch[b] & ~port.drain[b];
			assign drive_oe[b] = ~port.direction[b] & ~(port.drain[b] & port.latch[b]);
		end
	endgenerate
endmodule
`default_nettype wire

// *** logic/sgp_pkg.sv ***
// Constants and types shared by the general purpose port logic
package sgp_pkg;
	localparam int PORT_COUNT = 7;
	localparam int PORT_WIDTH = 16;
	localparam int PIN_TOTAL = PORT_COUNT * PORT_WIDTH;
	localparam int ADDR_WIDTH = 12;
	// Port register map: port base is port index times PORT_STRIDE
	localparam logic [ADDR_WIDTH-1:0] PORT_STRIDE = 12'h010;
	localparam logic [1:0] REG_DIRECTION = 2'h0;
	localparam logic [1:0] REG_LATCH = 2'h1;
	localparam logic [1:0] REG_LEVEL = 2'h2;
	localparam logic [1:0] REG_DRAIN = 2'h3;
	localparam logic [ADDR_WIDTH-1:0] PORT_SPAN = 12'h070;
	localparam logic [ADDR_WIDTH-1:0] DEBUG_CONFIG_ADDR = 12'h100;
	localparam int TEST_ENABLE_BIT = 3;
	// Reset values
	localparam logic [PORT_WIDTH-1:0] DIRECTION_RESET = 16'hffff;
	localparam logic [PORT_WIDTH-1:0] LATCH_RESET = 16'h0000;
	localparam logic [PORT_WIDTH-1:0] DRAIN_RESET = 16'h0000;
	localparam logic TEST_ENABLE_RESET = 1'b1;
	// Bits present in ports A to G, lowest port in the lowest lanes
	localparam logic [PIN_TOTAL-1:0] PRESENT_MASK = {PORT_COUNT{16'hffff}};
	// Port indices
	localparam int PORT_A = 0;
	localparam int PORT_G = 6;
	// Pins shared with the boundary-scan test controller, all on port A
	localparam int TEST_MODE_BIT = 0;
	localparam int TEST_CLOCK_BIT = 1;
	localparam int TEST_DATA_IN_BIT = 4;
	localparam int TEST_DATA_OUT_BIT = 5;
	// Pins shared with the two-wire serial controller
	localparam int TWI_PORT = 0;
	localparam int TWI_CLOCK_BIT = 2;
	localparam int TWI_DATA_BIT = 3;
	// Board wiring of buttons and lamps
	localparam int BUTTON_ONE_BIT = 6;
	localparam int BUTTON_TWO_BIT = 7;
	localparam int BUTTON_THREE_BIT = 0;
	localparam int LED_ONE_BIT = 12;
	typedef enum logic [1:0] {
		SGP_ACC_IDLE,
		SGP_ACC_WAIT
	} sgp_access_e;
endpackage

// *** logic/sgp_port_if.sv ***
// Register strobes and register state of one port
`timescale 1ns/1ps
`default_nettype none
interface sgp_port_if;
	import sgp_pkg::*;
	logic wr_direction;
	logic wr_latch;
	logic wr_drain;
	logic [PORT_WIDTH-1:0] wdata;
	logic [PORT_WIDTH-1:0] direction;
	logic [PORT_WIDTH-1:0] latch;
	logic [PORT_WIDTH-1:0] drain;
	modport ctrl (output wr_direction, output wr_latch, output wr_drain, output wdata,
		input direction, input latch, input drain);
	modport regs (input wr_direction, input wr_latch, input wr_drain, input wdata,
		output direction, output latch, output drain);
	modport pads (input direction, input latch, input drain);
endinterface
`default_nettype wire

// *** logic/sgp_port_regs.sv ***
// Direction, latch and drain-type registers of one port
`timescale 1ns/1ps
`default_nettype none
module sgp_port_regs
	import sgp_pkg::*;
#(
	parameter logic [PORT_WIDTH-1:0] PRESENT = 16'hffff
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	sgp_port_if.regs port
);
	logic [PORT_WIDTH-1:0] direction_reg;
	logic [PORT_WIDTH-1:0] direction_next;
	logic [PORT_WIDTH-1:0] latch_reg;
	logic [PORT_WIDTH-1:0] latch_next;
	logic [PORT_WIDTH-1:0] drain_reg;
	logic [PORT_WIDTH-1:0] drain_next;

	// Absent bits hold their reset value
	always_comb begin
		direction_next = direction_reg;
		latch_next = latch_reg;
		drain_next = drain_reg;
		if (port.wr_direction) begin
			direction_next = (port.wdata & PRESENT) | (DIRECTION_RESET & ~PRESENT);
		end
		if (port.wr_latch) begin
			latch_next = port.wdata & PRESENT;
		end
		if (port.wr_drain) begin
			drain_next = port.wdata & PRESENT;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			direction_reg <= DIRECTION_RESET;
			latch_reg <= LATCH_RESET;
			drain_reg <= DRAIN_RESET;
		end else begin
			direction_reg <= direction_next;
			latch_reg <= latch_next;
			drain_reg <= drain_next;
		end
	end

	assign port.direction = direction_reg;
	assign port.latch = latch_reg;
	assign port.drain = drain_reg;
endmodule
`default_nettype wire
